// File: verilog/acu_control.sv
/*
 * acu_control: APB register slave and control logic for a six-channel
 * 8-bit converter. Assumes the analogue core holds result stable while
 * its end-of-conversion level is high, and that it runs asynchronously.
 */
// Overview of operation
// - eight-bit converter, six analogue inputs, unsigned eight-bit results
// - channel field bits 2..0: inputs 0..5, low ref 110, high ref 111
// - clock field bits 4..3: 6, 3, 1.5 or 0.75 MHz
// - start rising resets converter and result; falling with bit 6 set in the same write launches a conversion
// - bit 6 powers the converter on or off
// - bit 7 is active-low completion flag, zero when conversion finished
// - separate result register holds latest outcome in bits 7..0
// - low and high references bound the full-scale range
// - references selectable between external pins and internal rails
// - unused analogue or reference pins remain ordinary port lines
// - build option includes or excludes the converter; excluded is inert
// - endpoint status bit 6 selects internal rails when set, default set
`timescale 1ns/10ps
`default_nettype none

module acu_control #(
    parameter bit CONVERTER_PRESENT = 1'b1
) (
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [acu_pkg::ADDR_W-1:0]        paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    output logic                                   irq,
    output acu_pkg::acu_core_req_t                 core_req,
    input  wire acu_pkg::acu_core_rsp_t            core_rsp,
    output logic      [acu_pkg::NUM_PINS-1:0]      analog_pin_sel
);

    typedef struct packed {
        acu_pkg::acu_ctrl_t                ctrl;
        logic [acu_pkg::RESULT_W-1:0]      result;
        logic                              ref_internal;
        logic [7:0]                        irq_status;
        logic [7:0]                        irq_mask;
        logic [acu_pkg::ACC_W-1:0]         phase;
        logic                              clk_tick;
        logic                              core_start;
        logic                              busy;
        logic [2:0]                        eoc_sync;
        logic                              eoc_filt;
        logic [31:0]                       rdata;
    } acu_state_t;

    acu_state_t st_reg;
    acu_state_t st_next;

    localparam acu_state_t ST_RESET = '{
        ctrl:         acu_pkg::acu_ctrl_t'(acu_pkg::CTRL_RESET),
        result:       acu_pkg::RESULT_RESET,
        ref_internal: acu_pkg::REF_INT_RESET,
        irq_status:   8'h00,
        irq_mask:     8'h00,
        phase:        '0,
        clk_tick:     1'b0,
        core_start:   1'b0,
        busy:         1'b0,
        eoc_sync:     3'h0,
        eoc_filt:     1'b0,
        rdata:        32'h0000_0000
    };

    // word hit on a register index
    function automatic logic addr_hit(input logic [acu_pkg::ADDR_W-1:0] a,
                                      input logic [acu_pkg::IDX_W-1:0]  idx);
        addr_hit = (a[1:0] == 2'h0) && (a[acu_pkg::ADDR_W-1:2] == idx);
    endfunction

    function automatic logic addr_mapped(input logic [acu_pkg::ADDR_W-1:0] a);
        addr_mapped = addr_hit(a, acu_pkg::IDX_ENDPOINT_STATUS)
                   || addr_hit(a, acu_pkg::IDX_CONV_CTRL)
                   || addr_hit(a, acu_pkg::IDX_CONV_RESULT)
                   || addr_hit(a, acu_pkg::IDX_IRQ_STATUS)
                   || addr_hit(a, acu_pkg::IDX_IRQ_MASK);
    endfunction

    logic                          setup_phase;
    logic                          access_phase;
    logic                          wr_ctrl;
    logic                          wr_status;
    logic                          wr_mask;
    logic                          rd_irq;
    logic                          done_event;
    logic                          eoc_agree;
    logic [acu_pkg::ACC_W:0]       phase_sum;
    logic [7:0]                    wbyte;
    acu_pkg::acu_ctrl_t            wctrl;
    logic [7:0]                    rbyte;

    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign wbyte        = pwdata[7:0];
    assign wctrl        = acu_pkg::acu_ctrl_t'(wbyte);

    always_comb begin
        st_next    = st_reg;
        wr_ctrl    = access_phase && pwrite && addr_hit(paddr, acu_pkg::IDX_CONV_CTRL);
        wr_status  = access_phase && pwrite
                  && addr_hit(paddr, acu_pkg::IDX_ENDPOINT_STATUS);
        wr_mask    = access_phase && pwrite && addr_hit(paddr, acu_pkg::IDX_IRQ_MASK);
        rd_irq     = access_phase && !pwrite && addr_hit(paddr, acu_pkg::IDX_IRQ_STATUS);
        done_event = 1'b0;
        rbyte      = 8'h00;

        // end-of-conversion level from the analogue core, three-stage sync
        st_next.eoc_sync = {st_reg.eoc_sync[1:0], core_rsp.eoc};
        eoc_agree        = (st_reg.eoc_sync[1] == st_reg.eoc_sync[2]);
        if (eoc_agree) begin
            st_next.eoc_filt = st_reg.eoc_sync[2];
        end

        // conversion clock: phase accumulator, increment halved per code
        phase_sum = {1'b0, st_reg.phase}
                  + {1'b0, acu_pkg::CONV_INC >> st_reg.ctrl.clk_sel};
        st_next.phase    = phase_sum[acu_pkg::ACC_W-1:0];
        st_next.clk_tick = phase_sum[acu_pkg::ACC_W] && st_reg.ctrl.power;
        st_next.core_start = 1'b0;

        // result capture once the core reports completion
        if (st_reg.busy && eoc_agree && st_reg.eoc_sync[2] && !st_reg.eoc_filt) begin
            st_next.result      = core_rsp.result;
            st_next.ctrl.done_n = 1'b0;
            st_next.busy        = 1'b0;
            done_event          = 1'b1;
        end

        // control register write
        if (wr_ctrl) begin
            st_next.ctrl.channel = wctrl.channel;
            st_next.ctrl.clk_sel = wctrl.clk_sel;
            st_next.ctrl.power   = wctrl.power;
            st_next.ctrl.start   = wctrl.start;
            if (wctrl.start && !st_reg.ctrl.start) begin
                st_next.result = acu_pkg::RESULT_RESET;
                st_next.busy   = 1'b0;
            end
            if (!wctrl.start && st_reg.ctrl.start && wctrl.power) begin
                st_next.core_start  = 1'b1;
                st_next.ctrl.done_n = 1'b1;
                st_next.busy        = 1'b1;
                done_event          = 1'b0;
            end
            if (!wctrl.power) begin
                st_next.busy = 1'b0;
            end
        end

        if (wr_status) begin
            st_next.ref_internal = wbyte[acu_pkg::REF_INT_BIT];
        end
        if (wr_mask) begin
            st_next.irq_mask = wbyte;
        end

        // sticky status: read clears, a new event wins
        if (rd_irq) begin
            st_next.irq_status = 8'h00;
        end
        if (done_event) begin
            st_next.irq_status[acu_pkg::IRQ_DONE_BIT] = 1'b1;
        end

        // read data captured in the setup phase
        if (setup_phase && !pwrite) begin
            if (addr_hit(paddr, acu_pkg::IDX_CONV_CTRL)) begin
                rbyte = st_reg.ctrl;
            end else if (addr_hit(paddr, acu_pkg::IDX_CONV_RESULT)) begin
                rbyte = st_reg.result;
            end else if (addr_hit(paddr, acu_pkg::IDX_ENDPOINT_STATUS)) begin
                rbyte[acu_pkg::REF_INT_BIT] = st_reg.ref_internal;
            end else if (addr_hit(paddr, acu_pkg::IDX_IRQ_STATUS)) begin
                rbyte = st_reg.irq_status;
            end else if (addr_hit(paddr, acu_pkg::IDX_IRQ_MASK)) begin
                rbyte = st_reg.irq_mask;
            end
            st_next.rdata = {24'h00_0000, rbyte};
        end

        // build option off: state held at reset values except irq_mask and rdata
        if (!CONVERTER_PRESENT) begin
            st_next          = ST_RESET;
            st_next.irq_mask = st_reg.irq_mask;
            st_next.rdata    = st_reg.rdata;
            if (wr_mask) begin
                st_next.irq_mask = wbyte;
            end
            if (setup_phase && !pwrite) begin
                st_next.rdata = (addr_hit(paddr, acu_pkg::IDX_IRQ_MASK))
                              ? {24'h00_0000, st_reg.irq_mask} : 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // bus answer: always ready, error on unmapped word
    assign pready  = 1'b1;
    assign pslverr = access_phase && !addr_mapped(paddr);
    assign prdata  = st_reg.rdata;

    assign irq = |(st_reg.irq_status & st_reg.irq_mask);

    // requests to the analogue core
    always_comb begin
        core_req.power        = st_reg.ctrl.power;
        core_req.conv_reset   = st_reg.ctrl.start;
        core_req.start        = st_reg.core_start;
        core_req.ref_internal = st_reg.ref_internal;
        core_req.clk_tick     = st_reg.clk_tick;
        core_req.clk_sel      = st_reg.ctrl.clk_sel;
        core_req.channel      = st_reg.ctrl.channel;
    end

    // pins claimed by the converter; the rest stay port lines
    always_comb begin
        analog_pin_sel = '0;
        if (st_reg.ctrl.power) begin
            analog_pin_sel[st_reg.ctrl.channel] = 1'b1;
            if (!st_reg.ref_internal) begin
                analog_pin_sel[acu_pkg::CH_LOW_REF]  = 1'b1;
                analog_pin_sel[acu_pkg::CH_HIGH_REF] = 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// File: verilog/acu_pkg.sv
/*
 * acu_pkg: constants and carrier types for the converter control unit.
 * Assumes a 100 MHz pclk and an APB register bus with 32-bit data.
 */
`default_nettype none

package acu_pkg;

    // clocking
    localparam longint unsigned PCLK_HZ      = 100_000_000;
    localparam longint unsigned CONV_BASE_HZ = 6_000_000;
    localparam int              ACC_W        = 16;
    // phase increment for the fastest conversion clock
    localparam logic [ACC_W-1:0] CONV_INC =
        ACC_W'((CONV_BASE_HZ << ACC_W) / PCLK_HZ);

    // register indices; byte address is four times the index
    localparam int              ADDR_W              = 10;
    localparam int              IDX_W               = 8;
    localparam logic [IDX_W-1:0] IDX_ENDPOINT_STATUS = 8'h1B;
    localparam logic [IDX_W-1:0] IDX_CONV_CTRL       = 8'h1D;
    localparam logic [IDX_W-1:0] IDX_CONV_RESULT     = 8'h1E;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS      = 8'h20;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK        = 8'h21;

    // field positions
    localparam int REF_INT_BIT  = 6;
    localparam int IRQ_DONE_BIT = 0;
    localparam int RESULT_W     = 8;
    localparam int NUM_PINS     = 8;

    // channel codes
    localparam logic [2:0] CH_LOW_REF  = 3'h6;
    localparam logic [2:0] CH_HIGH_REF = 3'h7;

    // reset values
    localparam logic [7:0] CTRL_RESET     = 8'h80;
    localparam logic       REF_INT_RESET  = 1'b1;
    localparam logic [7:0] RESULT_RESET   = 8'h00;

    typedef struct packed {
        logic       done_n;
        logic       power;
        logic       start;
        logic [1:0] clk_sel;
        logic [2:0] channel;
    } acu_ctrl_t;

    typedef struct packed {
        logic       power;
        logic       conv_reset;
        logic       start;
        logic       ref_internal;
        logic       clk_tick;
        logic [1:0] clk_sel;
        logic [2:0] channel;
    } acu_core_req_t;

    typedef struct packed {
        logic        eoc;
        logic [7:0]  result;
    } acu_core_rsp_t;

endpackage

`default_nettype wire

// File: dv/acu_control_asserts.sv
/* acu_control_asserts: port checks for acu_control.
   assumes one pclk domain and attachment by bind. */
`timescale 1ns/10ps
`default_nettype none
module acu_control_asserts #(parameter bit CONVERTER_PRESENT = 1'b1) (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [9:0]             paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pslverr,
    input wire logic                   irq,
    input wire acu_pkg::acu_core_req_t core_req,
    input wire logic [7:0]             analog_pin_sel
);
    logic       wr_c;
    logic       wr_q1;
    logic       wr_q2;
    logic [7:0] last_w;
    logic       last_ref;
    assign wr_c = psel && penable && pwrite && paddr == 10'h074;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q1 <= 1'b0;
            wr_q2 <= 1'b0;
            last_w <= 8'h80;
            last_ref <= 1'b1;
        end else begin
            wr_q1 <= psel && penable && pwrite;
            wr_q2 <= wr_q1;
            if (wr_c) begin
                last_w <= pwdata[7:0];
            end
            if (psel && penable && pwrite && paddr == 10'h06C) begin
                last_ref <= pwdata[6];
            end
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_mirror;
        CONVERTER_PRESENT && !wr_q1 && !wr_q2 |-> core_req.channel == last_w[2:0]
            && core_req.clk_sel == last_w[4:3] && core_req.power == last_w[6]
            && core_req.conv_reset == last_w[5] && core_req.ref_internal == last_ref;
    endproperty
    a_mirror: assert property (p_mirror) else $error("control fields off");
    property p_launch;
        CONVERTER_PRESENT && wr_c && last_w[5] && !pwdata[5] && pwdata[6] |-> ##[1:2] core_req.start;
    endproperty
    a_launch: assert property (p_launch) else $error("no launch");
    property p_pulse;
        core_req.start |=> !core_req.start;
    endproperty
    a_pulse: assert property (p_pulse) else $error("start too long");
    property p_tick;
        core_req.clk_tick |=> (!core_req.clk_tick)[*8];
    endproperty
    a_tick: assert property (p_tick) else $error("tick too fast");
    property p_pins;
        !wr_q1 && !wr_q2 |-> analog_pin_sel == (core_req.power ? (8'h01 << core_req.channel)
            | (core_req.ref_internal ? 8'h00 : 8'hC0) : 8'h00);
    endproperty
    a_pins: assert property (p_pins) else $error("pin claim off");
    property p_irq_clr;
        psel && penable && !pwrite && paddr == 10'h080 |=> !irq;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq kept");
    property p_slverr;
        psel && penable && !(paddr inside {10'h06C, 10'h074, 10'h078, 10'h080, 10'h084})
            |-> pslverr;
    endproperty
    a_slverr: assert property (p_slverr) else $error("no slave error");
    property p_upper;
        prdata[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    c_launch: cover property (core_req.start);
    c_irq: cover property (irq);
    c_err: cover property (pslverr);
endmodule
bind acu_control acu_control_asserts #(.CONVERTER_PRESENT(CONVERTER_PRESENT)) acu_control_asserts_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .core_req(core_req), .analog_pin_sel(analog_pin_sel));
`default_nettype wire

// File: dv/acu_core_model.sv
/* acu_core_model: behavioural conversion core.
   assumes core_req from acu_control, pclk domain. */
`timescale 1ns/10ps
`default_nettype none
module acu_core_model #(parameter int TICKS = 4) (
    input  wire acu_pkg::acu_core_req_t core_req,
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    output acu_pkg::acu_core_rsp_t      core_rsp
);
    int   left;
    logic busy;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            left <= 0;
            core_rsp <= '0;
        end else begin
            if (!core_rsp.eoc) begin
                core_rsp.result <= ~core_rsp.result;
            end
            if (core_req.conv_reset || !core_req.power) begin
                busy <= 1'b0;
                core_rsp.eoc <= 1'b0;
            end else if (core_req.start) begin
                busy <= 1'b1;
                left <= TICKS;
            end else if (busy && core_req.clk_tick) begin
                left <= left - 1;
                if (left == 1) begin
                    busy <= 1'b0;
                    core_rsp.eoc <= 1'b1;
                    // low ref reads 00, high ref FF
                    core_rsp.result <= core_req.channel == 3'h6 ? 8'h00 :
                        core_req.channel == 3'h7 ? 8'hFF : 8'h20 * core_req.channel + 8'h15;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/testbench.sv
/* testbench: directed tests of acu_control with the core model.
   assumes acu_pkg compiled first; pclk 100 MHz. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic                   pclk = 1'b0;
    logic                   presetn = 1'b0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [9:0]             paddr = 10'h000;
    logic [31:0]            pwdata = 32'h0;
    logic [31:0]            prdata;
    logic [31:0]            q;
    logic                   pready;
    logic                   pslverr;
    logic                   err;
    logic                   irq;
    logic [7:0]             pin_sel;
    acu_pkg::acu_core_req_t core_req;
    acu_pkg::acu_core_rsp_t core_rsp;
    int                     n_mismatch = 0;
    int                     total_checks = 0;
    always #5 pclk = ~pclk;
    acu_control acu_control_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .core_req(core_req), .core_rsp(core_rsp),
        .analog_pin_sel(pin_sel));
    acu_core_model acu_core_model_i (.pclk(pclk), .presetn(presetn), .core_req(core_req),
        .core_rsp(core_rsp));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_reset;
        apb(0, 10'h074, 0); chk(q, 32'h80);
        apb(0, 10'h078, 0); chk(q, 32'h00);
        apb(0, 10'h06C, 0); chk(q, 32'h40);
        apb(0, 10'h084, 0); chk(q, 32'h00);
    endtask
    task automatic t_errors;
        apb(0, 10'h088, 0); chk({31'h0, err}, 1);
        apb(1, 10'h078, 32'hA5); apb(0, 10'h078, 0); chk(q, 0);
        apb(1, 10'h074, 32'h00); apb(0, 10'h074, 0); chk(q, 32'h80);
    endtask
    task automatic t_convert(input logic [2:0] ch, input logic [1:0] ck, input logic msk);
        logic [7:0] exp;
        int n;
        n = 0;
        exp = ch == 3'h6 ? 8'h00 : ch == 3'h7 ? 8'hFF : 8'h20 * ch + 8'h15;
        apb(1, 10'h084, {31'h0, msk});
        apb(1, 10'h074, {24'h0, 3'b011, ck, ch});
        apb(0, 10'h078, 0); chk(q, 0);
        apb(1, 10'h074, {24'h0, 3'b010, ck, ch});
        apb(0, 10'h074, 0); chk({31'h0, q[7]}, 1);
        do begin
            apb(0, 10'h074, 0);
            n++;
        end while (q[7] !== 1'b0 && n < 400);
        chk(q, {24'h0, 3'b010, ck, ch});
        apb(0, 10'h078, 0); chk(q, {24'h0, exp});
        chk({31'h0, irq}, {31'h0, msk});
        apb(0, 10'h080, 0); chk(q, 1);
        chk({31'h0, irq}, 0);
    endtask
    task automatic t_pins;
        apb(1, 10'h06C, 0); apb(1, 10'h074, 32'h42); chk({24'h0, pin_sel}, 32'hC4);
        apb(0, 10'h06C, 0); chk(q, 0);
        apb(1, 10'h074, 0); chk({24'h0, pin_sel}, 0);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        print_verdict;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_errors;
        for (int i = 0; i < 8; i++) begin
            t_convert(3'(i), 2'(i), i != 3);
        end
        t_pins;
        print_verdict;
    end
endmodule
`default_nettype wire
